// ===== src/lutr_top.sv
// Configurable 16x1 lookup-table memory: level, rising and falling write variants
`timescale 1ns/1ns
`include "lutr_params.svh"

module lutr_top
  import lutr_pkg::*;
#(
  parameter lutr_variant_t VARIANT = LUTR_DP_RISE,
  parameter lutr_word_t INIT_VALUE = `LUTR_INIT_ZERO,
  parameter logic WCLK_INVERT = `LUTR_WCLK_INV_DEFAULT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic wr_clk,
  input wire logic data_in,
  input wire lutr_addr_t addr,
  input wire lutr_addr_t read_only_address,
  output logic write_port_read_out,
  output logic read_port_out
);

  // ------------------------------------------------------------
  // Variant decode
  // ------------------------------------------------------------
  localparam logic IS_LEVEL = (VARIANT == LUTR_LEVEL); // RULE15
  localparam logic IS_DUAL = (VARIANT == LUTR_DP_RISE) || (VARIANT == LUTR_DP_FALL); // RULE15
  localparam logic IS_FALL = (VARIANT == LUTR_DP_FALL);

  // ------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ------------------------------------------------------------
  lutr_top_st_t st_q;
  lutr_top_st_t st_d;
  lutr_pins_t pins;
  logic eff_clk;
  logic clk_rise;
  logic clk_fall;
  logic wr_evt;
  lutr_addr_t port_b_addr;
  lutr_word_t contents;

  always_comb begin
    pins.we = wr_en;
    pins.wclk = wr_clk;
    pins.din = data_in;
    pins.waddr = addr;
    pins.raddr = read_only_address;
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.wclk_prev = st_q.s2.wclk ^ WCLK_INVERT;
  end

  // Previous edge level starts at the idle sense, so no false edge follows reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '{s1: '0, s2: '0, wclk_prev: WCLK_INVERT};
    end else begin
      st_q <= st_d;
    end
  end

  // Inverter on the clock input is absorbed here
  assign eff_clk = st_q.s2.wclk ^ WCLK_INVERT; // RULE10
  assign clk_rise = eff_clk & ~st_q.wclk_prev;
  assign clk_fall = ~eff_clk & st_q.wclk_prev;

  // ------------------------------------------------------------
  // Write qualification
  // ------------------------------------------------------------
  always_comb begin
    if (IS_LEVEL) begin
      wr_evt = st_q.s2.we; // RULE1 RULE3
    end else if (IS_FALL) begin
      wr_evt = st_q.s2.we & clk_fall; // RULE9 RULE7
    end else begin
      wr_evt = st_q.s2.we & clk_rise; // RULE8 RULE7
    end
  end

  // Second port follows its own address only on dual-port parts
  assign port_b_addr = IS_DUAL ? st_q.s2.raddr : st_q.s2.waddr; // RULE6 RULE12 RULE13

  lutr_store #(
    .INIT_VALUE(INIT_VALUE)
  ) u_store (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(wr_evt),
    .wr_addr(st_q.s2.waddr), // RULE13
    .wr_bit(st_q.s2.din),
    .rd_addr_a(st_q.s2.waddr), // RULE2 RULE11 RULE14
    .rd_addr_b(port_b_addr),
    .out_a(write_port_read_out),
    .out_b(read_port_out),
    .contents(contents)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic sel_a;
  logic sel_b;
  lutr_word_t wr_mask;

  always_comb begin
    sel_a = contents[st_q.s2.waddr];
    sel_b = contents[port_b_addr];
    wr_mask = '0;
    wr_mask[st_q.s2.waddr] = 1'b1;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  level_store_a: assert property ( // RULE1
    IS_LEVEL && st_q.s2.we |=> contents[$past(st_q.s2.waddr)] == $past(st_q.s2.din)
  ) else $error("level write did not store data");

  hold_contents_a: assert property ( // RULE3
    !wr_evt |=> contents == $past(contents)
  ) else $error("contents changed without a write");

  idle_clock_a: assert property ( // RULE7
    !st_q.s2.we |-> !wr_evt
  ) else $error("write taken with enable low");

  rise_write_a: assert property ( // RULE8
    (VARIANT == LUTR_SP_RISE || VARIANT == LUTR_DP_RISE) && st_q.s2.we
      && $rose(st_q.s2.wclk ^ WCLK_INVERT)
      |=> contents[$past(st_q.s2.waddr)] == $past(st_q.s2.din)
  ) else $error("rising edge write missed");

  fall_write_a: assert property ( // RULE9
    IS_FALL && $rose(st_q.s2.wclk ^ WCLK_INVERT) |-> !wr_evt
  ) else $error("falling variant wrote on rising edge");

  fall_store_a: assert property ( // RULE9
    IS_FALL && st_q.s2.we && $fell(st_q.s2.wclk ^ WCLK_INVERT)
      |=> contents[$past(st_q.s2.waddr)] == $past(st_q.s2.din)
  ) else $error("falling edge write missed");

  port_a_view_a: assert property ( // RULE11
    !$past(sys_rst) |-> write_port_read_out == $past(sel_a)
  ) else $error("first output not the word at write address");

  port_b_view_a: assert property ( // RULE12
    !$past(sys_rst) |-> read_port_out == $past(sel_b)
  ) else $error("second output not the word at its address");

  only_target_a: assert property ( // RULE13
    ##1 ((contents ^ $past(contents)) & ~$past(wr_mask)) == '0
  ) else $error("write touched a word other than the target");

  init_load_a: assert property ( // RULE5
    $fell(sys_rst) |-> contents == INIT_VALUE
  ) else $error("contents not at initial value after reset");

  single_view_a: assert property ( // RULE14
    !IS_DUAL ##1 ($stable(contents) && $stable(st_q.s2.waddr)) [*2]
      |-> $stable(write_port_read_out)
  ) else $error("single-port output changed with no cause");

  write_cov_c: cover property (wr_evt ##1 $changed(contents));
  dual_cov_c: cover property (IS_DUAL && wr_evt && st_q.s2.raddr != st_q.s2.waddr);
  idle_cov_c: cover property (!st_q.s2.we && $rose(st_q.s2.wclk));
  level_cov_c: cover property (IS_LEVEL && st_q.s2.we [*3]);

endmodule

// ===== inc/lutr_params.svh
// Constants for the 16x1 lookup-table memory family
//
// What this block does
// [RULE1] Level variant writes while write enable high
// [RULE2] Level variant output shows addressed word always
// [RULE3] Level variant holds contents while enable low
// [RULE4] Hex initial value, 1-bit 16/32 deep only; this model is 16 deep only (LUTR_DEPTH 16)
// [RULE5] No initial value means all words zero
// [RULE6] Dual-port: separate write and read addresses
// [RULE7] Enable low: clock edges ignored, contents kept
// [RULE8] Rising variants: write on rising clock edge
// [RULE9] Falling variant: write on falling edge only
// [RULE10] Either clock polarity, default active high
// [RULE11] First output shows word at write address
// [RULE12] Second output shows word at read address
// [RULE13] Read address never affects any write
// [RULE14] Single-port output follows address and contents
// [RULE15] Variant and initial value chosen by parameters
`ifndef LUTR_PARAMS_SVH
`define LUTR_PARAMS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define LUTR_DEPTH 16
`define LUTR_AW 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LUTR_INIT_ZERO 16'h0000
`define LUTR_WCLK_INV_DEFAULT 1'b0

`endif

// ===== inc/lutr_pkg.sv
// Types shared by the 16x1 lookup-table memory family
`include "lutr_params.svh"

package lutr_pkg;

  typedef enum {
    LUTR_LEVEL,
    LUTR_SP_RISE,
    LUTR_DP_RISE,
    LUTR_DP_FALL
  } lutr_variant_t;

  typedef logic [`LUTR_AW-1:0] lutr_addr_t;
  typedef logic [`LUTR_DEPTH-1:0] lutr_word_t;

  typedef struct packed {
    logic we;
    logic wclk;
    logic din;
    lutr_addr_t waddr;
    lutr_addr_t raddr;
  } lutr_pins_t;

  typedef struct packed {
    lutr_pins_t s1;
    lutr_pins_t s2;
    logic wclk_prev;
  } lutr_top_st_t;

  typedef struct packed {
    lutr_word_t mem;
    logic out_a;
    logic out_b;
  } lutr_store_st_t;

endpackage

// ===== src/lutr_store.sv
// Sixteen one-bit cells with two registered read ports
`timescale 1ns/1ns
`include "lutr_params.svh"

module lutr_store
  import lutr_pkg::*;
#(
  parameter lutr_word_t INIT_VALUE = `LUTR_INIT_ZERO
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire lutr_addr_t wr_addr,
  input wire logic wr_bit,
  input wire lutr_addr_t rd_addr_a,
  input wire lutr_addr_t rd_addr_b,
  output logic out_a,
  output logic out_b,
  output lutr_word_t contents
);

  lutr_store_st_t st_q;
  lutr_store_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.out_a = st_q.mem[rd_addr_a];
    st_d.out_b = st_q.mem[rd_addr_b];
    if (wr_en) begin
      st_d.mem[wr_addr] = wr_bit;
    end
  end

  // Reset stands in for configuration: cells take the initial value
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '{mem: INIT_VALUE, out_a: 1'b0, out_b: 1'b0}; // RULE4 RULE5
    end else begin
      st_q <= st_d;
    end
  end

  assign out_a = st_q.out_a;
  assign out_b = st_q.out_b;
  assign contents = st_q.mem;

endmodule

// ===== sim/lutr_user.sv
// User logic model that drives the memory pins
`timescale 1ns/1ns

module lutr_user
  import lutr_pkg::*;
(
  input wire logic mclk,
  output logic wr_en,
  output logic wr_clk,
  output logic data_in,
  output lutr_addr_t addr,
  output lutr_addr_t read_only_address
);
  initial begin
    wr_en = 1'b0;
    wr_clk = 1'b0;
    data_in = 1'b0;
    addr = 4'h0;
    read_only_address = 4'h0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Data flips between the rising and the falling clock edge
  task automatic write(input lutr_addr_t a, input logic d, input logic en);
    @(negedge mclk);
    addr = a;
    read_only_address = a ^ 4'h5;
    data_in = d;
    wr_en = en;
    idle(4);
    wr_clk = 1'b1;
    idle(4);
    data_in = ~d;
    idle(4);
    wr_clk = 1'b0;
    idle(4);
    wr_en = 1'b0;
    idle(4);
  endtask

  task automatic point(input lutr_addr_t a, input lutr_addr_t r);
    @(negedge mclk);
    addr = a;
    read_only_address = r;
    idle(5);
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench running all memory variants and an inverted-clock copy side by side
`timescale 1ns/1ns

module testbench;
  import lutr_pkg::*;
  logic mclk;
  logic sys_rst;
  logic wr_en;
  logic wr_clk;
  logic data_in;
  lutr_addr_t addr;
  lutr_addr_t raddr;
  logic [4:0] wpo;
  logic [4:0] rpo;
  lutr_word_t exp_mem [5];
  int bad_count;
  int cmp_count;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  lutr_user lutr_user_i (.mclk(mclk), .wr_en(wr_en), .wr_clk(wr_clk), .data_in(data_in),
    .addr(addr), .read_only_address(raddr));

  // Copy 4 is the rising single-port part with an inverted write clock
  for (genvar g = 0; g < 5; g++) begin : gen_v
    lutr_top #(.VARIANT(lutr_variant_t'(g == 4 ? 1 : g)),
      .INIT_VALUE(g == 3 ? 16'h0000 : 16'habac), .WCLK_INVERT(g == 4))
      lutr_top_i (.mclk(mclk), .sys_rst(sys_rst), .wr_en(wr_en), .wr_clk(wr_clk),
      .data_in(data_in), .addr(addr), .read_only_address(raddr),
      .write_port_read_out(wpo[g]), .read_port_out(rpo[g]));
  end

  task automatic chk(input logic seen, input logic want, input string what);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Second port reads the mirrored address on dual variants
  task automatic sweep();
    for (int a = 0; a < 16; a++) begin
      lutr_user_i.point(a[3:0], ~a[3:0]);
      for (int g = 0; g < 5; g++) begin
        chk(wpo[g], exp_mem[g][a], "first port word");
        chk(rpo[g], exp_mem[g][(g == 2 || g == 3) ? 15 - a : a], "second port word");
      end
    end
  endtask

  task automatic do_write(input lutr_addr_t a, input logic d, input logic en);
    lutr_user_i.write(a, d, en);
    if (en) begin
      exp_mem[0][a] = ~d;
      exp_mem[1][a] = d;
      exp_mem[2][a] = d;
      exp_mem[3][a] = ~d;
      exp_mem[4][a] = ~d;
    end
  endtask

  task automatic init_exp();
    for (int g = 0; g < 5; g++) begin
      exp_mem[g] = (g == 3) ? 16'h0000 : 16'habac;
    end
  endtask

  // Reset in mid-run reloads the initial contents
  task automatic t_reset();
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    init_exp();
    sweep();
    $display("test reset done");
  endtask

  task automatic t_init();
    sweep();
    $display("test init done");
  endtask

  task automatic t_write();
    for (int a = 0; a < 16; a++) begin
      do_write(a[3:0], a[1] ^ a[3], 1'b1);
    end
    do_write(4'hf, 1'b1, 1'b1);
    sweep();
    $display("test write done");
  endtask

  task automatic t_ignore();
    for (int a = 0; a < 4; a++) begin
      do_write(a[3:0], ~exp_mem[1][a], 1'b0);
    end
    sweep();
    $display("test ignore done");
  endtask

  initial begin
    repeat (6000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    init_exp();
    sys_rst = 1'b1;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    t_init();
    t_write();
    t_ignore();
    t_reset();
    end_of_test();
  end
endmodule
